/* rtl/remote_monitor_pkg.sv */
package remote_monitor_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_PAYLOAD_LOW   = 8'hd0;
	localparam logic [7:0] OFS_PAYLOAD_MID   = 8'hd1;
	localparam logic [7:0] OFS_PAYLOAD_HIGH  = 8'hd2;
	localparam logic [7:0] OFS_MOD_INDEX     = 8'hd3;
	localparam logic [7:0] OFS_TX_CONTROL    = 8'hd4;
	localparam logic [7:0] OFS_RX_CONTROL    = 8'hd5;
	localparam logic [7:0] OFS_GROUP_SELECT  = 8'hd6;
	localparam logic [7:0] OFS_VENDOR_SELECT = 8'hd7;
	localparam logic [7:0] OFS_SEC_MASK      = 8'hd8;
	localparam logic [7:0] OFS_SEC_GLOBAL    = 8'hd9;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_TX_ENABLE     = 0;
	localparam int BIT_SEND_REQUEST  = 2;
	localparam int BIT_ENABLE_REQ    = 3;
	localparam int BIT_RX_ENABLE     = 0;
	localparam int BIT_GLOBAL_INHIB  = 7;
	localparam int BIT_KIND          = 23;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_BYTE  = 8'h00;
	localparam logic [6:0] RST_INDEX = 7'h00;

	// ----------------------------------------
	// Frame codes and values
	// ----------------------------------------
	localparam logic [10:0] HDR_CONTROL       = 11'h2a0;
	localparam logic [10:0] HDR_SEC_IDLE      = 11'h2ab;
	localparam logic [23:0] PAYLOAD_ENABLE    = 24'h905401;
	localparam logic [7:0]  FILL_BYTE         = 8'hcc;
	localparam logic [6:0]  INDEX_OFF         = 7'h00;
	localparam logic [6:0]  INDEX_MIN         = 7'h0a;
	localparam logic [6:0]  INDEX_MAX         = 7'h64;
	localparam logic [7:0]  REMOTE_PAGE_BASE  = 8'h80;
	localparam logic [7:0]  TUNE_FIRST        = 8'h80;
	localparam logic [7:0]  TUNE_LAST         = 8'hab;

	// ----------------------------------------
	// Streamed group lengths in bytes
	// ----------------------------------------
	localparam logic [10:0] LEN_INVENTORY = 11'h060;
	localparam logic [10:0] LEN_DIAG      = 11'h018;
	localparam logic [10:0] LEN_STATUS    = 11'h010;
	localparam logic [10:0] LEN_G0        = 11'h020;
	localparam logic [10:0] LEN_G1        = 11'h080;
	localparam logic [10:0] LEN_G2        = 11'h068;
	localparam logic [10:0] LEN_G3        = 11'h080;
	localparam logic [10:0] LEN_G4        = 11'h040;
	localparam logic [10:0] LEN_G5        = 11'h020;
	localparam logic [10:0] LEN_G6        = 11'h080;

endpackage

/* rtl/remote_cmd_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module remote_cmd_decode
	import remote_monitor_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        rx_frame_valid,
	input  wire logic [10:0] rx_frame_header_type,
	input  wire logic [23:0] rx_frame_payload,
	input  wire logic        header_check_err,
	input  wire logic        payload_check_err,
	output logic             rwr_valid_ff,
	output logic [7:0]       rwr_addr_ff,
	output logic [7:0]       rwr_data_ff,
	output logic             page_request_ff,
	output logic             discard_ff
);
	logic       nxt_rwr_valid;
	logic [7:0] nxt_rwr_addr;
	logic [7:0] nxt_rwr_data;
	logic       nxt_page_request;
	logic       nxt_discard;
	logic       clean;
	logic       is_control;

	// ----------------------------------------
	// Frame screening and write decode
	// ----------------------------------------
	always_comb
	begin
		is_control = (rx_frame_header_type == HDR_CONTROL);
		clean = rx_frame_valid && !header_check_err && !payload_check_err;
		nxt_discard = rx_frame_valid && (header_check_err || payload_check_err);
		nxt_rwr_valid = clean && is_control && rx_frame_payload[BIT_KIND];
		nxt_page_request = clean && is_control && !rx_frame_payload[BIT_KIND];
		nxt_rwr_addr = REMOTE_PAGE_BASE | rx_frame_payload[15:8];
		nxt_rwr_data = rx_frame_payload[7:0];
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rwr_valid_ff    <= 1'b0;
			rwr_addr_ff     <= RST_BYTE;
			rwr_data_ff     <= RST_BYTE;
			page_request_ff <= 1'b0;
			discard_ff      <= 1'b0;
		end
		else
		begin
			rwr_valid_ff    <= nxt_rwr_valid;
			rwr_addr_ff     <= nxt_rwr_addr;
			rwr_data_ff     <= nxt_rwr_data;
			page_request_ff <= nxt_page_request;
			discard_ff      <= nxt_discard;
		end
	end

	bad_frame_dropped_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		rx_frame_valid && (header_check_err || payload_check_err)
		|=> discard_ff && !rwr_valid_ff && !page_request_ff)
		else $error("errored frame was not discarded");

endmodule // remote_cmd_decode
`default_nettype wire

/* rtl/remote_monitor_tx_control.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - three bytes form payload, low to high
// - high byte write sends control frame
// - refuse unsafe remote writes like tuning
// - header and payload checked independently
// - errored frames are discarded
// - index zero turns transmitter off
// - codes 1-9 act as 10
// - codes 10-100 give 1-10 percent
// - tx state field is read-only
// - enable request host-only, enables local tx
// - send request flag set by remote
// - tx enable bit, remotely settable
// - rx state field is read-only
// - rx disable stops path, locks cleared
// - rx enable changes only by host
// - selection bytes host-only; vendor select byte not stored, reads zero
// - group bits add fixed-length groups
// - inventory and diagnostics sent when enabled
// - full set after remote acknowledge
// - protected bytes replaced by fill
// - mask overrides remote requests
// - global inhibit sends only idle frames
// - control kind 0 requests, 1 writes
module remote_monitor_tx_control
	import remote_monitor_pkg::*;
#(
	parameter int LOCK_FLAGS = 4
)
(
	input  wire logic                  ref_clk,
	input  wire logic                  rstn,
	input  wire logic                  host_wr,
	input  wire logic                  host_rd,
	input  wire logic [7:0]            host_addr,
	input  wire logic [7:0]            host_wdata,
	output logic      [7:0]            host_rdata_ff,
	input  wire logic [3:0]            tx_fsm_state,
	input  wire logic [3:0]            rx_fsm_state,
	input  wire logic [LOCK_FLAGS-1:0] lock_raw,
	output logic      [LOCK_FLAGS-1:0] lock_ff,
	input  wire logic                  rx_frame_valid,
	input  wire logic [10:0]           rx_frame_header_type,
	input  wire logic [23:0]           rx_frame_payload,
	input  wire logic                  header_check_err,
	input  wire logic                  payload_check_err,
	input  wire logic                  inventory_ack,
	input  wire logic                  stream_in_valid,
	input  wire logic [3:0]            stream_in_group,
	input  wire logic [7:0]            stream_in_data,
	output logic                       stream_out_valid_ff,
	output logic      [7:0]            stream_out_data_ff,
	output logic                       ctl_frame_req_ff,
	output logic      [10:0]           ctl_frame_header_type_ff,
	output logic      [23:0]           ctl_frame_payload_ff,
	output logic                       tx_on_ff,
	output logic      [6:0]            tx_mod_code_ff,
	output logic                       rx_path_on_ff,
	output logic                       send_basic_ff,
	output logic                       send_full_ff,
	output logic                       idle_only_ff,
	output logic      [7:0]            stream_groups_ff,
	output logic      [10:0]           stream_bytes_ff,
	output logic                       ext_wr_ff,
	output logic      [7:0]            ext_wr_addr_ff,
	output logic      [7:0]            ext_wr_data_ff,
	output logic                       discard_ff
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [6:0] norm_index(input logic [6:0] code);
		if (code == INDEX_OFF)
			return INDEX_OFF;
		else if (code < INDEX_MIN)
			return INDEX_MIN;
		else if (code > INDEX_MAX)
			return INDEX_MAX;
		else
			return code;
	endfunction

	function automatic logic [10:0] group_bytes(input logic [7:0] sel);
		logic [10:0] sum;
		sum = LEN_DIAG + LEN_STATUS;
		if (sel[0]) sum = sum + LEN_G0;
		if (sel[1]) sum = sum + LEN_G1;
		if (sel[2]) sum = sum + LEN_G2;
		if (sel[3]) sum = sum + LEN_G3;
		if (sel[4]) sum = sum + LEN_G4;
		if (sel[5]) sum = sum + LEN_G5;
		if (sel[6]) sum = sum + LEN_G6;
		return sum;
	endfunction

	// ----------------------------------------
	// Remote command decode
	// ----------------------------------------
	logic       rwr_valid;
	logic [7:0] rwr_addr;
	logic [7:0] rwr_data;
	logic       page_request;

	remote_cmd_decode u_decode (
		.ref_clk              (ref_clk),
		.rstn                 (rstn),
		.rx_frame_valid       (rx_frame_valid && rx_path_on_ff),
		.rx_frame_header_type (rx_frame_header_type),
		.rx_frame_payload     (rx_frame_payload),
		.header_check_err     (header_check_err),
		.payload_check_err    (payload_check_err),
		.rwr_valid_ff         (rwr_valid),
		.rwr_addr_ff          (rwr_addr),
		.rwr_data_ff          (rwr_data),
		.page_request_ff      (page_request),
		.discard_ff           (discard_ff)
	);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0]  pay_low_ff,   nxt_pay_low;
	logic [7:0]  pay_mid_ff,   nxt_pay_mid;
	logic [7:0]  pay_high_ff,  nxt_pay_high;
	logic        tx_en_ff,     nxt_tx_en;
	logic        en_req_ff,    nxt_en_req;
	logic        send_req_ff,  nxt_send_req;
	logic        rx_en_ff,     nxt_rx_en;
	logic [7:0]  group_sel_ff, nxt_group_sel;
	logic [7:0]  sec_mask_ff,  nxt_sec_mask;
	logic        inhibit_ff,   nxt_inhibit;
	logic [6:0]  nxt_mod_code;
	logic        nxt_ctl_req;
	logic [10:0] nxt_ctl_type;
	logic [23:0] nxt_ctl_payload;
	logic        nxt_ext_wr;
	logic [7:0]  nxt_rdata;
	logic        hw;
	logic        remote_ok;

	always_comb
	begin
		nxt_pay_low     = pay_low_ff;
		nxt_pay_mid     = pay_mid_ff;
		nxt_pay_high    = pay_high_ff;
		nxt_mod_code    = tx_mod_code_ff;
		nxt_tx_en       = tx_en_ff;
		nxt_en_req      = en_req_ff;
		nxt_send_req    = send_req_ff;
		nxt_rx_en       = rx_en_ff;
		nxt_group_sel   = group_sel_ff;
		nxt_sec_mask    = sec_mask_ff;
		nxt_inhibit     = inhibit_ff;
		nxt_ctl_req     = 1'b0;
		nxt_ctl_type    = ctl_frame_header_type_ff;
		nxt_ctl_payload = ctl_frame_payload_ff;
		nxt_ext_wr      = 1'b0;
		hw              = host_wr;
		// Remote writes: tx enable and index act, other local registers ignored, tuning refused, all else forwarded as ext write
		remote_ok = rwr_valid && !(rwr_addr >= TUNE_FIRST && rwr_addr <= TUNE_LAST);
		if (page_request)
			nxt_send_req = 1'b1;
		if (remote_ok)
		begin
			case (rwr_addr)
				OFS_TX_CONTROL:
				begin
					nxt_tx_en = rwr_data[BIT_TX_ENABLE];
					if (rwr_data[BIT_TX_ENABLE])
						nxt_send_req = 1'b1;
				end
				OFS_MOD_INDEX:
					nxt_mod_code = norm_index(rwr_data[6:0]);
				OFS_PAYLOAD_LOW, OFS_PAYLOAD_MID, OFS_PAYLOAD_HIGH, OFS_RX_CONTROL,
				OFS_GROUP_SELECT, OFS_VENDOR_SELECT, OFS_SEC_MASK, OFS_SEC_GLOBAL:
					nxt_ext_wr = 1'b0;
				default:
					nxt_ext_wr = 1'b1;
			endcase
		end
		// Host writes land after remote ones so the host wins a collision
		if (hw)
		begin
			case (host_addr)
				OFS_PAYLOAD_LOW:
					nxt_pay_low = host_wdata;
				OFS_PAYLOAD_MID:
					nxt_pay_mid = host_wdata;
				OFS_PAYLOAD_HIGH:
				begin
					nxt_pay_high    = host_wdata;
					nxt_ctl_req     = 1'b1;
					nxt_ctl_type    = HDR_CONTROL;
					nxt_ctl_payload = {host_wdata, pay_mid_ff, pay_low_ff};
				end
				OFS_MOD_INDEX:
					nxt_mod_code = norm_index(host_wdata[6:0]);
				OFS_TX_CONTROL:
				begin
					nxt_en_req = host_wdata[BIT_ENABLE_REQ];
					nxt_tx_en  = host_wdata[BIT_TX_ENABLE] | host_wdata[BIT_ENABLE_REQ];
					if (!nxt_tx_en)
						nxt_send_req = 1'b0;
					if (host_wdata[BIT_ENABLE_REQ])
					begin
						nxt_ctl_req     = 1'b1;
						nxt_ctl_type    = HDR_CONTROL;
						nxt_ctl_payload = PAYLOAD_ENABLE;
					end
				end
				OFS_RX_CONTROL:
					nxt_rx_en = host_wdata[BIT_RX_ENABLE];
				OFS_GROUP_SELECT:
					nxt_group_sel = {1'b0, host_wdata[6:0]};
				OFS_SEC_MASK:
					nxt_sec_mask = host_wdata;
				OFS_SEC_GLOBAL:
					nxt_inhibit = host_wdata[BIT_GLOBAL_INHIB];
				default:
					nxt_ext_wr = nxt_ext_wr;
			endcase
		end
		// Inhibit turns every outgoing control frame into a security idle
		if (nxt_ctl_req && inhibit_ff)
		begin
			nxt_ctl_type    = HDR_SEC_IDLE;
			nxt_ctl_payload = 24'h000000;
		end
		case (host_addr)
			OFS_PAYLOAD_LOW:   nxt_rdata = pay_low_ff;
			OFS_PAYLOAD_MID:   nxt_rdata = pay_mid_ff;
			OFS_PAYLOAD_HIGH:  nxt_rdata = pay_high_ff;
			OFS_MOD_INDEX:     nxt_rdata = {1'b0, tx_mod_code_ff};
			OFS_TX_CONTROL:    nxt_rdata = {tx_fsm_state, en_req_ff, send_req_ff,
				1'b0, tx_en_ff};
			OFS_RX_CONTROL:    nxt_rdata = {rx_fsm_state, 3'b000, rx_en_ff};
			OFS_GROUP_SELECT:  nxt_rdata = group_sel_ff;
			OFS_SEC_MASK:      nxt_rdata = sec_mask_ff;
			OFS_SEC_GLOBAL:    nxt_rdata = {inhibit_ff, 7'h00};
			default:           nxt_rdata = RST_BYTE;
		endcase
		if (!host_rd)
			nxt_rdata = host_rdata_ff;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pay_low_ff               <= RST_BYTE;
			pay_mid_ff               <= RST_BYTE;
			pay_high_ff              <= RST_BYTE;
			tx_mod_code_ff           <= RST_INDEX;
			tx_en_ff                 <= 1'b0;
			en_req_ff                <= 1'b0;
			send_req_ff              <= 1'b0;
			rx_en_ff                 <= 1'b0;
			group_sel_ff             <= RST_BYTE;
			sec_mask_ff              <= RST_BYTE;
			inhibit_ff               <= 1'b0;
			ctl_frame_req_ff         <= 1'b0;
			ctl_frame_header_type_ff <= HDR_CONTROL;
			ctl_frame_payload_ff     <= 24'h000000;
			ext_wr_ff                <= 1'b0;
			ext_wr_addr_ff           <= RST_BYTE;
			ext_wr_data_ff           <= RST_BYTE;
			host_rdata_ff            <= RST_BYTE;
		end
		else
		begin
			pay_low_ff               <= nxt_pay_low;
			pay_mid_ff               <= nxt_pay_mid;
			pay_high_ff              <= nxt_pay_high;
			tx_mod_code_ff           <= nxt_mod_code;
			tx_en_ff                 <= nxt_tx_en;
			en_req_ff                <= nxt_en_req;
			send_req_ff              <= nxt_send_req;
			rx_en_ff                 <= nxt_rx_en;
			group_sel_ff             <= nxt_group_sel;
			sec_mask_ff              <= nxt_sec_mask;
			inhibit_ff               <= nxt_inhibit;
			ctl_frame_req_ff         <= nxt_ctl_req;
			ctl_frame_header_type_ff <= nxt_ctl_type;
			ctl_frame_payload_ff     <= nxt_ctl_payload;
			ext_wr_ff                <= nxt_ext_wr;
			ext_wr_addr_ff           <= rwr_addr;
			ext_wr_data_ff           <= rwr_data;
			host_rdata_ff            <= nxt_rdata;
		end
	end

	// ----------------------------------------
	// Path enables, streaming and masking
	// ----------------------------------------
	logic                  nxt_tx_on;
	logic                  nxt_send_full;
	logic                  nxt_stream_valid;
	logic [7:0]            nxt_stream_data;
	logic [LOCK_FLAGS-1:0] nxt_lock;

	always_comb
	begin
		nxt_tx_on = tx_en_ff && (tx_mod_code_ff != INDEX_OFF);
		nxt_lock = rx_en_ff ? lock_raw : '0;
		nxt_send_full = nxt_tx_on && (send_full_ff || inventory_ack);
		nxt_stream_valid = stream_in_valid && tx_on_ff;
		nxt_stream_data = stream_in_data;
		if (!stream_in_group[3] && sec_mask_ff[stream_in_group[2:0]])
			nxt_stream_data = FILL_BYTE;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tx_on_ff            <= 1'b0;
			rx_path_on_ff       <= 1'b0;
			lock_ff             <= '0;
			send_basic_ff       <= 1'b0;
			send_full_ff        <= 1'b0;
			idle_only_ff        <= 1'b0;
			stream_groups_ff    <= RST_BYTE;
			stream_bytes_ff     <= LEN_INVENTORY;
			stream_out_valid_ff <= 1'b0;
			stream_out_data_ff  <= RST_BYTE;
		end
		else
		begin
			tx_on_ff            <= nxt_tx_on;
			rx_path_on_ff       <= rx_en_ff;
			lock_ff             <= nxt_lock;
			send_basic_ff       <= nxt_tx_on;
			send_full_ff        <= nxt_send_full;
			idle_only_ff        <= inhibit_ff;
			stream_groups_ff    <= group_sel_ff;
			stream_bytes_ff     <= send_full_ff ? group_bytes(group_sel_ff)
				: (LEN_INVENTORY + LEN_DIAG);
			stream_out_valid_ff <= nxt_stream_valid;
			stream_out_data_ff  <= nxt_stream_data;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence high_write_s;
		host_wr && host_addr == OFS_PAYLOAD_HIGH && !inhibit_ff;
	endsequence

	trigger_sends_frame_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		high_write_s |=> ctl_frame_req_ff && ctl_frame_header_type_ff == HDR_CONTROL)
		else $error("high byte write did not send a control frame");

	payload_captured_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		high_write_s |=> ctl_frame_payload_ff
			== {$past(host_wdata), $past(pay_mid_ff), $past(pay_low_ff)})
		else $error("control payload not captured in byte order");

	zero_index_off_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		tx_mod_code_ff == INDEX_OFF |=> !tx_on_ff)
		else $error("transmitter on with zero index");

	low_code_clamp_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		host_wr && host_addr == OFS_MOD_INDEX && host_wdata[6:0] != 7'h00
			&& host_wdata[6:0] < INDEX_MIN |=> tx_mod_code_ff == INDEX_MIN)
		else $error("reserved index not clamped to ten");

	rx_off_unlocked_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		!rx_en_ff |=> lock_ff == '0 && !rx_path_on_ff)
		else $error("lock flags set with receiver off");

	rx_enable_host_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		!(host_wr && host_addr == OFS_RX_CONTROL) |=> $stable(rx_en_ff))
		else $error("receive enable changed without a host write");

	mask_fill_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		stream_in_valid && tx_on_ff && !stream_in_group[3] && sec_mask_ff[stream_in_group[2:0]]
		|=> stream_out_valid_ff && stream_out_data_ff == FILL_BYTE)
		else $error("protected byte leaked");

	inhibit_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		ctl_frame_req_ff && $past(inhibit_ff) |-> ctl_frame_header_type_ff == HDR_SEC_IDLE)
		else $error("frame other than idle sent under inhibit");

	enable_req_local_a: assert property (@(posedge ref_clk) disable iff (!rstn)
		host_wr && host_addr == OFS_TX_CONTROL && host_wdata[BIT_ENABLE_REQ]
		|=> tx_en_ff ##1 (tx_on_ff || tx_mod_code_ff == INDEX_OFF))
		else $error("enable request did not enable local transmitter");

endmodule // remote_monitor_tx_control
`default_nettype wire

/* verif/remote_peer_model.sv */
`timescale 1ns/1ps
`default_nettype none
module remote_peer_model
(
	input  wire logic   ref_clk,
	output logic        rx_frame_valid,
	output logic [10:0] rx_frame_header_type,
	output logic [23:0] rx_frame_payload,
	output logic        header_check_err,
	output logic        payload_check_err,
	output logic        inventory_ack
);
	initial
	begin
		rx_frame_valid = 1'b0;
		rx_frame_header_type = 11'h555;
		rx_frame_payload = 24'ha5a5a5;
		header_check_err = 1'b0;
		payload_check_err = 1'b0;
		inventory_ack = 1'b0;
	end

	// One-cycle frame after lag idle cycles; fields scrambled once it has passed
	task automatic send(input logic [10:0] hdr, input logic [23:0] pay, input logic herr,
		input logic perr, input int lag);
		repeat (lag) @(posedge ref_clk);
		@(posedge ref_clk);
		rx_frame_valid <= 1'b1;
		rx_frame_header_type <= hdr;
		rx_frame_payload <= pay;
		header_check_err <= herr;
		payload_check_err <= perr;
		@(posedge ref_clk);
		rx_frame_valid <= 1'b0;
		rx_frame_header_type <= ~hdr;
		rx_frame_payload <= ~pay;
		header_check_err <= ~herr;
		payload_check_err <= ~perr;
		#1;
	endtask

	task automatic ack_inventory();
		@(posedge ref_clk);
		inventory_ack <= 1'b1;
		@(posedge ref_clk);
		inventory_ack <= 1'b0;
		#1;
	endtask
endmodule // remote_peer_model
`default_nettype wire

/* verif/remote_monitor_tx_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module remote_monitor_tx_control_tb
	import remote_monitor_pkg::*;
;
	logic        ref_clk, rstn, host_wr, host_rd, rx_frame_valid, header_check_err;
	logic        payload_check_err, inventory_ack, stream_in_valid, stream_out_valid_ff;
	logic        ctl_frame_req_ff, tx_on_ff, rx_path_on_ff, send_basic_ff, send_full_ff;
	logic        idle_only_ff, ext_wr_ff, discard_ff;
	logic [3:0]  tx_fsm_state, rx_fsm_state, lock_raw, lock_ff, stream_in_group;
	logic [7:0]  host_addr, host_wdata, host_rdata_ff, stream_in_data, stream_out_data_ff;
	logic [7:0]  ext_wr_addr_ff, ext_wr_data_ff, r, wa, wd, stream_groups_ff;
	logic [10:0] rx_frame_header_type, ctl_frame_header_type_ff, stream_bytes_ff;
	logic [23:0] rx_frame_payload, ctl_frame_payload_ff;
	logic [6:0]  tx_mod_code_ff;
	logic [6:0]  codes [6] = '{7'h00, 7'h05, 7'h09, 7'h0a, 7'h37, 7'h64};
	logic [6:0]  expc  [6] = '{7'h00, 7'h0a, 7'h0a, 7'h0a, 7'h37, 7'h64};
	int          num_errors, num_checks, nd, nw;

	remote_monitor_tx_control DUT (.ref_clk, .rstn, .host_wr, .host_rd, .host_addr, .host_wdata,
		.host_rdata_ff, .tx_fsm_state, .rx_fsm_state, .lock_raw, .lock_ff, .rx_frame_valid,
		.rx_frame_header_type, .rx_frame_payload, .header_check_err, .payload_check_err,
		.inventory_ack, .stream_in_valid, .stream_in_group, .stream_in_data,
		.stream_out_valid_ff, .stream_out_data_ff, .ctl_frame_req_ff, .ctl_frame_header_type_ff,
		.ctl_frame_payload_ff, .tx_on_ff, .tx_mod_code_ff, .rx_path_on_ff, .send_basic_ff,
		.send_full_ff, .idle_only_ff, .stream_groups_ff, .stream_bytes_ff, .ext_wr_ff,
		.ext_wr_addr_ff, .ext_wr_data_ff, .discard_ff);

	remote_peer_model far (.ref_clk, .rx_frame_valid, .rx_frame_header_type, .rx_frame_payload,
		.header_check_err, .payload_check_err, .inventory_ack);

	// ----------------------------------------
	// Bus cycles and comparison
	// ----------------------------------------
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		host_wr <= 1'b1;
		host_addr <= a;
		host_wdata <= d;
		@(posedge ref_clk);
		host_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		host_rd <= 1'b1;
		host_addr <= a;
		@(posedge ref_clk);
		host_rd <= 1'b0;
		#1;
		r = host_rdata_ff;
	endtask

	task automatic stream(input logic [3:0] g, input logic [7:0] d);
		@(posedge ref_clk);
		stream_in_valid <= 1'b1;
		stream_in_group <= g;
		stream_in_data <= d;
		@(posedge ref_clk);
		stream_in_valid <= 1'b0;
		#1;
	endtask

	// Counts discard and remote-write pulses over a short window
	task automatic watch();
		nd = 0;
		nw = 0;
		repeat (4)
		begin
			nd += (discard_ff === 1'b1);
			nw += (ext_wr_ff === 1'b1);
			if (ext_wr_ff === 1'b1)
			begin
				wa = ext_wr_addr_ff;
				wd = ext_wr_data_ff;
			end
			tick();
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_host();
		for (int i = 0; i < 10; i++)
		begin
			rd(OFS_PAYLOAD_LOW + 8'(i));
			chk(r, 24'h0, "reset byte");
		end
		rd(8'hda);
		chk(r, 24'h0, "unmapped");
		chk(lock_ff, 24'h0, "lock off");
		wr(OFS_PAYLOAD_LOW, 8'h11);
		wr(OFS_PAYLOAD_MID, 8'h22);
		wr(OFS_PAYLOAD_HIGH, 8'h33);
		chk(ctl_frame_req_ff, 24'h1, "req");
		chk(ctl_frame_header_type_ff, HDR_CONTROL, "hdr");
		chk(ctl_frame_payload_ff, 24'h332211, "payload");
		wr(OFS_PAYLOAD_LOW, 8'h44);
		chk(ctl_frame_req_ff, 24'h0, "no req");
		chk(ctl_frame_payload_ff, 24'h332211, "held");
		@(posedge ref_clk);
		tx_fsm_state <= 4'ha;
		rx_fsm_state <= 4'h5;
		wr(OFS_RX_CONTROL, 8'h01);
		tick();
		chk(lock_ff, 24'hf, "lock on");
		wr(OFS_TX_CONTROL, 8'hf4);
		rd(OFS_TX_CONTROL);
		chk(r, 24'ha0, "tx ctl");
		rd(OFS_RX_CONTROL);
		chk(r, 24'h51, "rx ctl");
		$display("host test done");
	endtask

	task automatic t_remote();
		far.send(HDR_CONTROL, PAYLOAD_ENABLE, 1'b1, 1'b0, 0);
		watch();
		chk(24'(nd), 24'h1, "hdr err");
		far.send(HDR_CONTROL, PAYLOAD_ENABLE, 1'b0, 1'b1, 3);
		watch();
		chk(24'(nd), 24'h1, "pay err");
		rd(OFS_TX_CONTROL);
		chk(r & 8'h05, 24'h0, "no enable");
		far.send(HDR_CONTROL, 24'h010000, 1'b0, 1'b0, 0);
		watch();
		rd(OFS_TX_CONTROL);
		chk(r & 8'h05, 24'h4, "page request");
		wr(OFS_TX_CONTROL, 8'h00);
		far.send(HDR_CONTROL, PAYLOAD_ENABLE, 1'b0, 1'b0, 0);
		watch();
		rd(OFS_TX_CONTROL);
		chk(r & 8'h01, 24'h1, "remote enable");
		chk(r & 8'h04, 24'h4, "send flag");
		far.send(HDR_CONTROL, 24'h805500, 1'b0, 1'b0, 0);
		watch();
		chk(rx_path_on_ff, 24'h1, "rx kept");
		far.send(HDR_CONTROL, 24'h800012, 1'b0, 1'b0, 0);
		watch();
		chk(24'(nw), 24'h0, "tune refused");
		far.send(HDR_CONTROL, 24'h8030a5, 1'b0, 1'b0, 0);
		watch();
		chk({nw[7:0], wa, wd}, 24'h01b0a5, "remote write");
		$display("remote test done");
	endtask

	task automatic t_index();
		for (int i = 0; i < 6; i++)
		begin
			wr(OFS_MOD_INDEX, {1'b0, codes[i]});
			tick();
			chk(tx_mod_code_ff, expc[i], "code");
			chk(tx_on_ff, {23'h0, expc[i] != 7'h00}, "tx on");
		end
		wr(OFS_MOD_INDEX, 8'h1e);
		tick();
		chk(tx_mod_code_ff, 24'h1e, "band low");
		chk(send_basic_ff, 24'h1, "basic");
		chk(stream_bytes_ff, 24'h078, "basic bytes");
		far.ack_inventory();
		tick();
		chk(send_full_ff, 24'h1, "full");
		wr(OFS_SEC_MASK, 8'h01);
		stream(4'h0, 8'h5a);
		chk({stream_out_valid_ff, stream_out_data_ff}, {1'b1, FILL_BYTE}, "masked");
		stream(4'h8, 8'h5a);
		chk({stream_out_valid_ff, stream_out_data_ff}, 24'h15a, "open");
		wr(OFS_GROUP_SELECT, 8'hff);
		rd(OFS_GROUP_SELECT);
		chk(r, 24'h7f, "groups");
		chk(stream_groups_ff, 24'h7f, "stream groups");
		chk(stream_bytes_ff, 24'h290, "full bytes");
		wr(OFS_TX_CONTROL, 8'h08);
		chk(ctl_frame_payload_ff, PAYLOAD_ENABLE, "enable req");
		wr(OFS_SEC_GLOBAL, 8'h80);
		wr(OFS_PAYLOAD_HIGH, 8'h01);
		chk(ctl_frame_header_type_ff, HDR_SEC_IDLE, "idle");
		chk(idle_only_ff, 24'h1, "inhibit");
		$display("index test done");
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		give_verdict();
	end

	initial
	begin
		{rstn, host_wr, host_rd, stream_in_valid} = 4'h0;
		{host_addr, host_wdata, stream_in_data} = 24'h0;
		{tx_fsm_state, rx_fsm_state, stream_in_group} = 12'h0;
		lock_raw = 4'hf;
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		t_host();
		t_remote();
		t_index();
		give_verdict();
	end
endmodule // remote_monitor_tx_control_tb
`default_nettype wire
